// File: dgiu_unit.sv
/*
  dgiu_unit: diagnose instruction unit. Executes the privileged diagnose
  instruction against main storage, local storage registers, channel gates
  and the error-log switch.
  Assumes storage answers a read strobe with data in the next cycle, that the
  register port master follows the one-cycle strobe protocol, and that the
  event inputs are one-cycle pulses synchronous to clk.
*/
`timescale 1ns/1ns
module dgiu_unit (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // processor context and events
  input  wire logic        problem_state,
  input  wire logic        start_from_stop,
  input  wire logic        level_block_load,
  input  wire logic        stop_addr_toggle,
  input  wire logic        cs_resume_instr,
  // main storage
  output logic      [14:0] st_addr,
  output logic             st_rd,
  output logic             st_wr,
  output logic      [21:0] st_wdata,
  input  wire logic [21:0] st_rdata,
  // results
  output logic             done,
  output logic             machine_check,
  output logic             program_check,
  output logic             psw_priv_violation,
  output logic             psw_storage_error,
  output logic             error_log_en,
  output logic             chan_irq_inhibit,
  output logic             cycle_steal_inhibit
);

  // decoded function of an instruction word, used at issue and at completion
  function automatic dgiu_pkg::dgiu_fn_t fn_of(input logic [15:0] w);
    return dgiu_pkg::dgiu_fn_t'(w[dgiu_pkg::PB_FN_HI:dgiu_pkg::PB_FN_LO]);
  endfunction

  dgiu_pkg::dgiu_state_t state_q, state_d;  // sequencer
  logic [15:0] instr_q;                     // latched first instruction word
  logic        lsb_q;                       // odd byte address latched at issue
  logic [15:0] gpr0_q, gpr0_d;              // register 0
  logic        gpr0_ld;                     // sequencer loads register 0
  logic [15:0] gpr7_q;                      // register 7, storage address
  logic [7:0]  lsr_addr_q;                  // local register address
  logic [15:0] imm_q;                       // immediate data word
  logic        imm_ld;                      // local register copied out
  logic        lsr_we;                      // immediate copied in
  logic [15:0] lsr_mem [dgiu_pkg::LSR_DEPTH];  // local storage registers
  logic        st_rd_d, st_wr_d;            // storage strobes, next
  logic [14:0] st_addr_d;                   // storage address, next
  logic [21:0] st_wdata_d;                  // storage write word, next
  logic        mchk_d, pchk_d;              // interrupt pulses, next
  logic        log_set, chan_set;           // switch updates
  logic        go;                          // command accepted
  logic [15:0] enc_in;                      // word to encode
  logic [5:0]  enc_chk;                     // its check bits
  logic [15:0] cor_data;                    // corrected read data
  logic        err_single, err_double;      // read error class
  logic [15:0] merged;                      // corrected word with new byte
  logic [15:0] rdata_d;                     // register read mux

  // a command is only taken while idle; a write during execution is dropped
  assign go = reg_wr && (reg_addr == dgiu_pkg::REG_CMD) && (state_q == dgiu_pkg::ST_IDLE);

  // new byte dropped into the corrected word; even address is the high byte
  always_comb begin
    merged = cor_data;
    if (lsb_q) begin
      merged[7:0] = gpr0_q[7:0];
    end else begin
      merged[15:8] = gpr0_q[7:0];
    end
  end

  // the encoder protects register 0 at issue and the merged word on completion
  assign enc_in = (state_q == dgiu_pkg::ST_WAIT) ? merged : gpr0_q;

  dgiu_ecc u_ecc (
    .enc_data   (enc_in),
    .enc_check  (enc_chk),
    .dec_word   (st_rdata),
    .dec_data   (cor_data),
    .dec_single (err_single),
    .dec_double (err_double)
  );

  // sequencer decisions
  always_comb begin
    state_d    = state_q;
    gpr0_ld    = 1'b0;
    gpr0_d     = gpr0_q;
    imm_ld     = 1'b0;
    lsr_we     = 1'b0;
    st_rd_d    = 1'b0;
    st_wr_d    = 1'b0;
    st_addr_d  = st_addr;
    st_wdata_d = st_wdata;
    mchk_d     = 1'b0;
    pchk_d     = 1'b0;
    log_set    = 1'b0;
    chan_set   = 1'b0;
    case (state_q)
      dgiu_pkg::ST_IDLE: begin
        if (go) begin
          state_d   = dgiu_pkg::ST_DONE;
          st_addr_d = gpr7_q[15:1];
          if (problem_state) begin
            pchk_d = 1'b1;
          end else if (reg_wdata[dgiu_pkg::PB_SYSID]) begin
            // bits 10 and 11 are not looked at
            gpr0_ld = 1'b1;
            gpr0_d  = dgiu_pkg::SYS_ID;
          end else if (reg_wdata[dgiu_pkg::PB_LOG]) begin
            log_set = 1'b1;
          end else begin
            case (fn_of(reg_wdata))
              dgiu_pkg::FN_WORD: begin
                if (reg_wdata[dgiu_pkg::PB_DIR] && reg_wdata[dgiu_pkg::PB_ENABLE]) begin
                  // plain checked write needs no read
                  st_wr_d    = 1'b1;
                  st_wdata_d = {enc_chk, gpr0_q};
                end else begin
                  st_rd_d = 1'b1;
                  state_d = dgiu_pkg::ST_WAIT;
                end
              end
              dgiu_pkg::FN_BYTE: begin
                // every byte-side write is read-modify-write
                st_rd_d = 1'b1;
                state_d = dgiu_pkg::ST_WAIT;
              end
              dgiu_pkg::FN_LSR: begin
                if (reg_wdata[dgiu_pkg::PB_DIR]) begin
                  imm_ld = 1'b1;
                end else begin
                  lsr_we = 1'b1;
                end
              end
              default: begin
                chan_set = 1'b1;
              end
            endcase
          end
        end
      end
      dgiu_pkg::ST_WAIT: begin
        // first cycle carries the strobe; storage answers in the second cycle only,
        // so nothing is taken from the read bus until the strobe has dropped
        state_d = st_rd ? dgiu_pkg::ST_WAIT : dgiu_pkg::ST_DONE;
        if (!st_rd && instr_q[dgiu_pkg::PB_ENABLE] && err_double) begin
          mchk_d = 1'b1;
        end
        case ({st_rd, fn_of(instr_q) == dgiu_pkg::FN_BYTE, instr_q[dgiu_pkg::PB_DIR],
               instr_q[dgiu_pkg::PB_ENABLE]})
          4'b0000: begin
            gpr0_ld = 1'b1;
            gpr0_d  = st_rdata[15:0];
          end
          4'b0001: begin
            gpr0_ld = 1'b1;
            gpr0_d  = cor_data;
          end
          4'b0010: begin
            st_wr_d    = 1'b1;
            st_wdata_d = {st_rdata[21:16], gpr0_q};
          end
          4'b0100: begin
            gpr0_ld = 1'b1;
            gpr0_d  = {10'h000, st_rdata[21:16]};
          end
          4'b0101: begin
            gpr0_ld = 1'b1;
            gpr0_d  = {8'h00, lsb_q ? cor_data[7:0] : cor_data[15:8]};
          end
          4'b0110: begin
            st_wr_d    = 1'b1;
            st_wdata_d = {gpr0_q[5:0], st_rdata[15:0]};
          end
          4'b0111: begin
            st_wr_d    = 1'b1;
            st_wdata_d = {enc_chk, merged};
          end
          default: begin
            // strobe cycle: wait for the answer, the state chosen above stands
            gpr0_ld = 1'b0;
          end
        endcase
      end
      dgiu_pkg::ST_DONE: begin
        state_d = dgiu_pkg::ST_IDLE;
      end
      default: begin
        state_d = dgiu_pkg::ST_IDLE;
      end
    endcase
  end

  // sequencer state and latched instruction
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= dgiu_pkg::ST_IDLE;
      instr_q <= dgiu_pkg::RST_WORD;
      lsb_q   <= 1'b0;
      done    <= 1'b0;
    end else begin
      state_q <= state_d;
      done    <= (state_d == dgiu_pkg::ST_DONE);
      if (go) begin
        instr_q <= reg_wdata;
        lsb_q   <= gpr7_q[0];
      end
    end
  end

  // storage strobes, one cycle each
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_rd    <= 1'b0;
      st_wr    <= 1'b0;
      st_addr  <= 15'h0000;
      st_wdata <= 22'h000000;
    end else begin
      st_rd    <= st_rd_d;
      st_wr    <= st_wr_d;
      st_addr  <= st_addr_d;
      st_wdata <= st_wdata_d;
    end
  end

  // general registers; the sequencer wins over a port write in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gpr0_q     <= dgiu_pkg::RST_WORD;
      gpr7_q     <= dgiu_pkg::RST_WORD;
      lsr_addr_q <= 8'h00;
    end else begin
      if (gpr0_ld) begin
        gpr0_q <= gpr0_d;
      end else if (reg_wr && reg_addr == dgiu_pkg::REG_GPR0) begin
        gpr0_q <= reg_wdata;
      end
      if (reg_wr && reg_addr == dgiu_pkg::REG_GPR7) begin
        gpr7_q <= reg_wdata;
      end
      if (reg_wr && reg_addr == dgiu_pkg::REG_LSR_ADDR) begin
        lsr_addr_q <= reg_wdata[7:0];
      end
    end
  end

  // immediate word: filled from a local register on a copy-out
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      imm_q <= dgiu_pkg::RST_WORD;
    end else if (imm_ld) begin
      imm_q <= lsr_mem[lsr_addr_q];
    end else if (reg_wr && reg_addr == dgiu_pkg::REG_IMM) begin
      imm_q <= reg_wdata;
    end
  end

  // local storage registers; no reset, contents are machine parameters
  always_ff @(posedge clk) begin
    if (lsr_we) begin
      lsr_mem[lsr_addr_q] <= imm_q;
    end
  end

  // error-log switch; follows the word being taken, instr_q still holds the previous one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      error_log_en <= dgiu_pkg::RST_LOG_EN;
    end else if (log_set) begin
      error_log_en <= reg_wdata[dgiu_pkg::PB_ENABLE];
    end
  end

  // channel gates: the diagnose setting beats a release event in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chan_irq_inhibit    <= dgiu_pkg::RST_INHIBIT;
      cycle_steal_inhibit <= dgiu_pkg::RST_INHIBIT;
    end else begin
      if (chan_set) begin
        chan_irq_inhibit <= ~reg_wdata[dgiu_pkg::PB_ENABLE];
      end else if (start_from_stop || level_block_load) begin
        chan_irq_inhibit <= 1'b0;
      end
      if (chan_set) begin
        cycle_steal_inhibit <= ~reg_wdata[dgiu_pkg::PB_ENABLE];
      end else if (start_from_stop || level_block_load || stop_addr_toggle ||
                   cs_resume_instr) begin
        cycle_steal_inhibit <= 1'b0;
      end
    end
  end

  // interrupt pulses and sticky status word bits; a new event beats the clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      machine_check      <= 1'b0;
      program_check      <= 1'b0;
      psw_priv_violation <= 1'b0;
      psw_storage_error  <= 1'b0;
    end else begin
      machine_check <= mchk_d;
      program_check <= pchk_d;
      if (pchk_d) begin
        psw_priv_violation <= 1'b1;
      end else if (reg_wr && reg_addr == dgiu_pkg::REG_PSW &&
                   reg_wdata[dgiu_pkg::PSW_PRIV]) begin
        psw_priv_violation <= 1'b0;
      end
      if (mchk_d) begin
        psw_storage_error <= 1'b1;
      end else if (reg_wr && reg_addr == dgiu_pkg::REG_PSW &&
                   reg_wdata[dgiu_pkg::PSW_STOR]) begin
        psw_storage_error <= 1'b0;
      end
    end
  end

  // register read mux; unmapped offsets read zero
  always_comb begin
    rdata_d = 16'h0000;
    case (reg_addr)
      dgiu_pkg::REG_GPR0:     rdata_d = gpr0_q;
      dgiu_pkg::REG_GPR7:     rdata_d = gpr7_q;
      dgiu_pkg::REG_LSR_ADDR: rdata_d = {8'h00, lsr_addr_q};
      dgiu_pkg::REG_IMM:      rdata_d = imm_q;
      dgiu_pkg::REG_CMD:      rdata_d = instr_q;
      dgiu_pkg::REG_STATUS: begin
        rdata_d[dgiu_pkg::STS_BUSY] = (state_q != dgiu_pkg::ST_IDLE);
        rdata_d[dgiu_pkg::STS_LOG]  = error_log_en;
        rdata_d[dgiu_pkg::STS_IRQ]  = chan_irq_inhibit;
        rdata_d[dgiu_pkg::STS_CS]   = cycle_steal_inhibit;
      end
      dgiu_pkg::REG_PSW: begin
        rdata_d[dgiu_pkg::PSW_PRIV] = psw_priv_violation;
        rdata_d[dgiu_pkg::PSW_STOR] = psw_storage_error;
      end
      default: rdata_d = 16'h0000;
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

endmodule // dgiu_unit

// File: dgiu_pkg.sv
/*
  dgiu_pkg: constants and types shared by the diagnose instruction unit and its
  check-bit coder.
  Assumes a 16-bit data path, a 22-bit storage word (six check bits above the
  data) and a byte-addressed register port with word-aligned offsets.
*/
package dgiu_pkg;

  // widths
  localparam int DW        = 16;   // data word
  localparam int CW        = 6;    // check bits per storage word
  localparam int SW        = 22;   // storage word, check bits on top
  localparam int RAW       = 8;    // register port address
  localparam int SAW       = 15;   // storage word address (byte address / 2)
  localparam int LSR_DEPTH = 256;  // local storage registers
  localparam int LAW       = 8;    // local storage register address

  // register port offsets
  localparam logic [7:0] REG_GPR0     = 8'h00;  // register 0 of the current level
  localparam logic [7:0] REG_GPR7     = 8'h04;  // register 7 of the current level
  localparam logic [7:0] REG_LSR_ADDR = 8'h08;  // local register address, low 8 bits
  localparam logic [7:0] REG_IMM      = 8'h0c;  // immediate data word
  localparam logic [7:0] REG_CMD      = 8'h10;  // write: first instruction word, starts
  localparam logic [7:0] REG_STATUS   = 8'h14;  // read only: unit state
  localparam logic [7:0] REG_PSW      = 8'h18;  // status word bits, write one to clear

  // parameter field positions inside the first instruction word (bit 0 is the msb)
  localparam int PB_FN_HI  = 7;  // instruction bit 8
  localparam int PB_FN_LO  = 6;  // instruction bit 9
  localparam int PB_DIR    = 3;  // instruction bit 12
  localparam int PB_SYSID  = 2;  // instruction bit 13
  localparam int PB_ENABLE = 1;  // instruction bit 14
  localparam int PB_LOG    = 0;  // instruction bit 15

  // status register fields
  localparam int STS_BUSY = 0;
  localparam int STS_LOG  = 1;
  localparam int STS_IRQ  = 2;
  localparam int STS_CS   = 3;

  // status word register fields
  localparam int PSW_PRIV = 0;  // privilege violation, status word bit 2
  localparam int PSW_STOR = 1;  // storage error, status word bit 8

  // values after reset
  localparam logic [15:0] RST_WORD    = 16'h0000;
  localparam logic        RST_LOG_EN  = 1'b1;
  localparam logic        RST_INHIBIT = 1'b0;

  // system identification word; the value is arbitrary
  localparam logic [15:0] SYS_ID = 16'h5a3c;

  // check-bit matrix: one odd-weight column per data bit
  localparam logic [5:0] ECC_COL [16] = '{
    6'h07, 6'h0b, 6'h0d, 6'h0e, 6'h13, 6'h15, 6'h16, 6'h19,
    6'h1a, 6'h1c, 6'h23, 6'h25, 6'h26, 6'h29, 6'h2a, 6'h2c
  };

  // function select, parameter bits 8 and 9
  typedef enum logic [1:0] {
    FN_WORD = 2'b00,
    FN_BYTE = 2'b01,
    FN_LSR  = 2'b10,
    FN_CHAN = 2'b11
  } dgiu_fn_t;

  // sequencer states, gray along idle -> wait -> done
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_DONE = 2'b11
  } dgiu_state_t;

endpackage

// File: dgiu_ecc.sv
/*
  dgiu_ecc: combinational check-bit coder, one encoder and one decoder.
  Assumes the caller registers everything it takes from here.
*/
`timescale 1ns/1ns
module dgiu_ecc (
  // encoder
  input  wire logic [15:0] enc_data,   // word to protect
  output logic      [5:0]  enc_check,  // its check bits
  // decoder
  input  wire logic [21:0] dec_word,   // stored word, check bits on top
  output logic      [15:0] dec_data,   // corrected data
  output logic             dec_single, // one bit was wrong
  output logic             dec_double  // uncorrectable error
);

  // check bits of a data word, xor of matrix columns
  function automatic logic [5:0] gen_check(input logic [15:0] d);
    logic [5:0] c;
    c = 6'h00;
    for (int i = 0; i < 16; i++) begin
      if (d[i]) begin
        c = c ^ dgiu_pkg::ECC_COL[i];
      end
    end
    return c;
  endfunction

  logic [5:0] syn;   // syndrome
  logic       hit;   // syndrome names a data bit

  // encoder
  always_comb begin
    enc_check = gen_check(enc_data);
  end

  // decoder: a data-bit column flips that bit, a single set bit is a check-bit
  // error; anything else nonzero is flagged and the data passes uncorrected
  always_comb begin
    syn      = gen_check(dec_word[15:0]) ^ dec_word[21:16];
    dec_data = dec_word[15:0];
    hit      = 1'b0;
    for (int i = 0; i < 16; i++) begin
      if (syn == dgiu_pkg::ECC_COL[i]) begin
        dec_data[i] = ~dec_word[i];
        hit         = 1'b1;
      end
    end
    dec_single = hit | ((syn != 6'h00) && ((syn & (syn - 6'h01)) == 6'h00));
    dec_double = (syn != 6'h00) && !dec_single;
  end

endmodule // dgiu_ecc

// File: dgiu_monitor.sv
/*
  dgiu_monitor: port-level checks of the diagnose instruction unit.
  Assumes it is bound to dgiu_unit and that everything runs on clk.
*/
`timescale 1ns/1ns
module dgiu_monitor (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // processor events
  input wire logic        start_from_stop,
  input wire logic        level_block_load,
  input wire logic        stop_addr_toggle,
  input wire logic        cs_resume_instr,
  // storage port
  input wire logic        st_rd,
  input wire logic        st_wr,
  input wire logic [21:0] st_wdata,
  // results
  input wire logic        done,
  input wire logic        machine_check,
  input wire logic        program_check,
  input wire logic        psw_priv_violation,
  input wire logic        psw_storage_error,
  input wire logic        error_log_en,
  input wire logic        chan_irq_inhibit,
  input wire logic        cycle_steal_inhibit
);
  logic [5:0] gen_c;  // check bits the written data should carry

  // own coder from the column table, independent of the design's coder
  always_comb begin
    gen_c = 6'h00;
    for (int i = 0; i < 16; i++) begin
      if (st_wdata[i]) gen_c ^= dgiu_pkg::ECC_COL[i];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_log_hold: assert property ($changed(error_log_en) |-> done)
    else $error("log enable moved without an instruction");
  a_wr_ecc: assert property (st_wr && !$past(st_rd) && !$past(st_rd, 2) |-> st_wdata[21:16] == gen_c)
    else $error("written check bits do not match data");
  a_rd_finish: assert property (st_rd |-> ##[1:2] done)
    else $error("storage read not followed by completion");
  a_wr_finish: assert property (st_wr |-> done)
    else $error("storage write outside completion cycle");
  a_mc_read: assert property (machine_check |-> $past(st_rd) || $past(st_rd, 2))
    else $error("machine check without a storage read");
  a_mc_flag: assert property (machine_check |-> ##[0:1] psw_storage_error)
    else $error("storage error bit not set");
  a_priv_set: assert property (program_check |-> ##[0:1] psw_priv_violation)
    else $error("privilege bit not set");
  a_priv_quiet: assert property (program_check |-> done && !st_rd && !st_wr)
    else $error("suppressed instruction touched storage");
  a_inh_cause: assert property ($rose(chan_irq_inhibit) || $rose(cycle_steal_inhibit) |-> done)
    else $error("inhibit set without an instruction");
  a_chan_clear: assert property (($past(start_from_stop) || $past(level_block_load)) && !done
      |-> !chan_irq_inhibit && !cycle_steal_inhibit)
    else $error("inhibits survived start or block load");
  a_cs_resume: assert property (($past(stop_addr_toggle) || $past(cs_resume_instr)) && !done
      |-> !cycle_steal_inhibit)
    else $error("cycle steal not resumed");

  // main scenarios reached
  c_mcheck: cover property (machine_check);
  c_pcheck: cover property (program_check);
  c_rmw: cover property (st_wr && $past(st_rd, 2));
endmodule // dgiu_monitor

bind dgiu_unit dgiu_monitor u_mon (.clk, .rst_n, .start_from_stop, .level_block_load,
  .stop_addr_toggle, .cs_resume_instr, .st_rd, .st_wr, .st_wdata, .done, .machine_check,
  .program_check, .psw_priv_violation, .psw_storage_error, .error_log_en,
  .chan_irq_inhibit, .cycle_steal_inhibit);

// File: dgiu_storage_model.sv
/*
  dgiu_storage_model: behavioural main storage of 22-bit words.
  Assumes one-cycle read strobes answered in the next cycle, no wait states.
*/
`timescale 1ns/1ns
module dgiu_storage_model (
  // clock
  input  wire logic        clk,
  // storage port from the unit
  input  wire logic [14:0] st_addr,
  input  wire logic        st_rd,
  input  wire logic        st_wr,
  input  wire logic [21:0] st_wdata,
  // read answer
  output logic      [21:0] st_rdata
);
  logic [21:0] mem_q [32768];  // check bits on top, data below
  logic [21:0] out_q;          // data bus

  // plain always: the bench also pokes errors into the array
  // answer stands one cycle, then the bus inverts so a late sample cannot pass
  always @(posedge clk) begin
    if (st_wr) mem_q[st_addr] <= st_wdata;
    if (st_rd) out_q <= mem_q[st_addr];
    else out_q <= ~out_q;
  end
  assign st_rdata = out_q;
endmodule // dgiu_storage_model

// File: testbench.sv
/*
  testbench: self-checking bench for dgiu_unit with a storage model.
  Assumes the one-cycle strobe register port and a 20 MHz clock.
*/
`timescale 1ns/1ns
module testbench;
  logic        clk = 1'b0;          // 50 ns period
  logic        rst_n = 1'b0;        // async reset
  logic [7:0]  reg_addr = 8'h00;    // register port
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic        pstate = 1'b0;       // problem state
  logic [3:0]  evt = 4'h0;          // start, block load, stop toggle, resume
  logic [14:0] st_addr;
  logic        st_rd, st_wr;
  logic [21:0] st_wdata, st_rdata;
  logic        done, mc, pc, priv, serr, log_en, irq_inh, cs_inh;
  logic        rd_pend = 1'b0;      // a read answer is due
  logic        mc_seen, pc_seen;    // pulses caught while waiting
  logic [15:0] q[$];                // expected read data, oldest first
  logic [15:0] d, a, nd;            // random data, address, merged word
  int          error_cnt = 0;
  int          checks_done = 0;

  always #25 clk = ~clk;

  dgiu_unit u_dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .problem_state(pstate), .start_from_stop(evt[0]), .level_block_load(evt[1]),
    .stop_addr_toggle(evt[2]), .cs_resume_instr(evt[3]), .st_addr, .st_rd, .st_wr,
    .st_wdata, .st_rdata, .done, .machine_check(mc), .program_check(pc),
    .psw_priv_violation(priv), .psw_storage_error(serr), .error_log_en(log_en),
    .chan_irq_inhibit(irq_inh), .cycle_steal_inhibit(cs_inh));
  dgiu_storage_model u_mem (.clk, .st_addr, .st_rd, .st_wr, .st_wdata, .st_rdata);

  // reference coder, written apart from the design's
  function automatic logic [5:0] ecc(input logic [15:0] v);
    ecc = 6'h00;
    for (int i = 0; i < 16; i++) begin
      if (v[i]) ecc ^= dgiu_pkg::ECC_COL[i];
    end
  endfunction

  task automatic chk(input logic [21:0] seen, input logic [21:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("errors %0d, checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // one-cycle write strobe; a gap cycle follows so strobes never collide
  task automatic wr(input logic [7:0] ad, input logic [15:0] dt);
    @(posedge clk);
    reg_addr <= ad;
    reg_wdata <= dt;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // one-cycle read strobe; the watcher compares the answer
  task automatic rd(input logic [7:0] ad, input logic [15:0] ex);
    @(posedge clk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    q.push_back(ex);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask

  // issue one instruction word and wait, bounded, for its completion
  task automatic run(input logic [7:0] p);
    mc_seen = 1'b0;
    pc_seen = 1'b0;
    wr(dgiu_pkg::REG_CMD, {8'h00, p});
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      mc_seen |= mc;
      pc_seen |= pc;
      if (done === 1'b1) begin
        @(posedge clk);
        return;
      end
    end
    chk(1'b0, 1'b1);
    end_sim();
  endtask

  task automatic pulse(input int k);
    @(posedge clk);
    evt[k] <= 1'b1;
    @(posedge clk);
    evt[k] <= 1'b0;
    @(posedge clk);
  endtask

  // read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_pend) chk(reg_rdata, q.pop_front());
    rd_pend <= reg_rd;
  end

  initial begin
    void'($urandom(85226));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk({log_en, irq_inh, cs_inh}, 3'b100);
    rd(dgiu_pkg::REG_STATUS, 16'h0002);
    rd(8'h1c, 16'h0000);
    // identification wins over logging and channel bits
    run(8'hc5);
    chk({log_en, irq_inh, cs_inh}, 3'b100);
    rd(dgiu_pkg::REG_GPR0, dgiu_pkg::SYS_ID);
    run(8'hc1);
    chk({log_en, irq_inh, cs_inh}, 3'b000);
    run(8'h03);
    chk(log_en, 1'b1);
    run(8'h01);
    chk(log_en, 1'b0);
    // each clearing event against a fresh channel inhibit
    for (int k = 0; k < 4; k++) begin
      run(8'hc0);
      chk({irq_inh, cs_inh}, 2'b11);
      pulse(k);
      chk({irq_inh, cs_inh}, {k > 1, 1'b0});
    end
    run(8'hc2);
    chk({irq_inh, cs_inh}, 2'b00);
    // checked word write, corrected read, double error
    d = 16'($urandom);
    a = 16'($urandom);
    wr(dgiu_pkg::REG_GPR0, d);
    wr(dgiu_pkg::REG_GPR7, a);
    run(8'h0a);
    chk(u_mem.mem_q[a[15:1]], {ecc(d), d});
    u_mem.mem_q[a[15:1]] ^= 22'h000008;
    run(8'h02);
    chk(mc_seen, 1'b0);
    rd(dgiu_pkg::REG_GPR0, d);
    u_mem.mem_q[a[15:1]] ^= 22'h000020;
    run(8'h02);
    chk(mc_seen, 1'b1);
    rd(dgiu_pkg::REG_PSW, 16'h0002);
    chk(serr, 1'b1);
    wr(dgiu_pkg::REG_PSW, 16'h0002);
    rd(dgiu_pkg::REG_PSW, 16'h0000);
    // raw word read and write
    run(8'h00);
    chk(mc_seen, 1'b0);
    rd(dgiu_pkg::REG_GPR0, d ^ 16'h0028);
    wr(dgiu_pkg::REG_GPR0, ~d);
    run(8'h08);
    chk(u_mem.mem_q[a[15:1]], {ecc(d), ~d});
    // check-bit read and write
    run(8'h40);
    rd(dgiu_pkg::REG_GPR0, {10'h000, ecc(d)});
    wr(dgiu_pkg::REG_GPR0, 16'hffd5);
    run(8'h48);
    chk(u_mem.mem_q[a[15:1]], {6'h15, ~d});
    // checked byte read of the low byte, write of the high byte
    u_mem.mem_q[a[15:1]] = {ecc(d), d};
    wr(dgiu_pkg::REG_GPR7, {a[15:1], 1'b1});
    run(8'h42);
    rd(dgiu_pkg::REG_GPR0, {8'h00, d[7:0]});
    nd = {~d[7:0], d[7:0]};
    wr(dgiu_pkg::REG_GPR0, {8'hff, ~d[7:0]});
    wr(dgiu_pkg::REG_GPR7, {a[15:1], 1'b0});
    run(8'h4a);
    chk(u_mem.mem_q[a[15:1]], {ecc(nd), nd});
    // local register round trip
    wr(dgiu_pkg::REG_LSR_ADDR, {8'h00, a[7:0]});
    wr(dgiu_pkg::REG_IMM, d);
    run(8'h80);
    wr(dgiu_pkg::REG_IMM, 16'h0000);
    run(8'h88);
    rd(dgiu_pkg::REG_IMM, d);
    // problem state suppresses a checked write
    pstate <= 1'b1;
    run(8'h0a);
    pstate <= 1'b0;
    chk(pc_seen, 1'b1);
    chk(u_mem.mem_q[a[15:1]], {ecc(nd), nd});
    rd(dgiu_pkg::REG_PSW, 16'h0001);
    chk(priv, 1'b1);
    repeat (3) @(posedge clk);
    end_sim();
  end
endmodule // testbench
